/* hdl/iosf_pkg.sv */
package iosf_pkg;
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_MASK   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IMAGE  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h10;
    // channel counts and image layout
    localparam int NUM_DI      = 11;
    localparam int NUM_DO      = 2;
    localparam int BYTE_W      = 8;
    localparam int B1_DI_LSB   = 0;
    localparam int B1_SEAL0    = 3;
    localparam int B1_COIL_LSB = 4;
    localparam int B1_PWR_LSB  = 6;
    localparam int CMD_DO_LSB  = 0;
    // status events
    localparam int EV_W        = 3;
    localparam int EV_TIMEOUT  = 0;
    localparam int EV_FAILSAFE = 1;
    localparam int EV_UPDATE   = 2;
    localparam logic [EV_W-1:0] MASK_RST = 3'h0;
    // control and output-view fields
    localparam int   CTRL_FS_EN     = 0;
    localparam logic CTRL_FS_EN_RST = 1'b1;
    localparam int   OUT_DO_LSB     = 0;
    localparam int   OUT_SEAL_LSB   = 2;
    localparam int   OUT_STATE_LSB  = 4;
    localparam int   STATE_W        = 2;
    // timing
    localparam int CNT_W              = 32;
    localparam int CLK_MHZ            = 125;
    localparam int US_PER_MS          = 1000;
    localparam int SCAN_PERIOD_US     = 1000;
    localparam int LINK_TIMEOUT_MS    = 100;
    localparam int SCAN_CYCLES_DEF    = SCAN_PERIOD_US * CLK_MHZ;
    localparam int TIMEOUT_CYCLES_DEF = LINK_TIMEOUT_MS * US_PER_MS * CLK_MHZ;
    typedef enum logic [STATE_W-1:0] {LINK_OK, LINK_CHECK, LINK_APPLY, LINK_LOST} iosf_link_type;
endpackage

/* hdl/iosf_scan_if.sv */
interface iosf_scan_if;
    import iosf_pkg::*;
    logic [NUM_DI-1:0] di;
    logic [NUM_DO-1:0] coil;
    logic [NUM_DO-1:0] pwr;
    logic [NUM_DO-1:0] seal_stat;
    logic [NUM_DO-1:0] seal_cfg;
    logic [NUM_DO-1:0] sealed;
    logic              scan_tick;
    modport sampler (output di, coil, pwr, seal_stat, seal_cfg, scan_tick, input sealed);
    modport user    (input di, coil, pwr, seal_stat, seal_cfg, scan_tick, output sealed);
endinterface

/* hdl/iosf_scan.sv */
module iosf_scan
    import iosf_pkg::*;
#(
    parameter int SCAN_CYCLES = SCAN_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // board pins, true levels
    input  wire logic [NUM_DI-1:0] discrete_input,
    input  wire logic [NUM_DO-1:0] coil_ok_pin,
    input  wire logic [NUM_DO-1:0] power_ok_pin,
    input  wire logic [NUM_DO-1:0] seal_volt_pin,
    input  wire logic [NUM_DO-1:0] latch_enable_switch,
    // image toward the core
    iosf_scan_if.sampler           sc
);
    localparam int SW_LSB = 0;
    localparam int SV_LSB = NUM_DO;
    localparam int PW_LSB = 2 * NUM_DO;
    localparam int CO_LSB = 3 * NUM_DO;
    localparam int DI_LSB = 4 * NUM_DO;
    localparam int PIN_W  = NUM_DI + 4 * NUM_DO;

    logic [PIN_W-1:0]  meta_r, meta_nxt, sync_r, sync_nxt;
    logic [CNT_W-1:0]  cnt_r, cnt_nxt;
    logic              tick_r, tick_nxt;
    logic [NUM_DI-1:0] di_r, di_nxt;
    logic [NUM_DO-1:0] coil_r, coil_nxt, pwr_r, pwr_nxt;
    logic [NUM_DO-1:0] seal_r, seal_nxt, cfg_r, cfg_nxt;

    always_comb
    begin
        meta_nxt = {discrete_input, coil_ok_pin, power_ok_pin, seal_volt_pin, latch_enable_switch};
        sync_nxt = meta_r;
        tick_nxt = (cnt_r == CNT_W'(SCAN_CYCLES - 1));
        cnt_nxt  = tick_nxt ? '0 : cnt_r + 1'b1;
        // seal-in is armed only with field voltage and the switch closed
        cfg_nxt  = sync_r[SV_LSB +: NUM_DO] & sync_r[SW_LSB +: NUM_DO];
        di_nxt   = di_r;
        coil_nxt = coil_r;
        pwr_nxt  = pwr_r;
        seal_nxt = seal_r;
        if (tick_r)
        begin
            di_nxt   = sync_r[DI_LSB +: NUM_DI];
            coil_nxt = sync_r[CO_LSB +: NUM_DO];
            pwr_nxt  = sync_r[PW_LSB +: NUM_DO];
            seal_nxt = sc.sealed;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            meta_r <= '0;
            sync_r <= '0;
            cnt_r  <= '0;
            tick_r <= 1'b0;
            di_r   <= '0;
            coil_r <= '0;
            pwr_r  <= '0;
            seal_r <= '0;
            cfg_r  <= '0;
        end
        else
        begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
            cnt_r  <= cnt_nxt;
            tick_r <= tick_nxt;
            di_r   <= di_nxt;
            coil_r <= coil_nxt;
            pwr_r  <= pwr_nxt;
            seal_r <= seal_nxt;
            cfg_r  <= cfg_nxt;
        end
    end

    assign sc.di        = di_r;
    assign sc.coil      = coil_r;
    assign sc.pwr       = pwr_r;
    assign sc.seal_stat = seal_r;
    assign sc.seal_cfg  = cfg_r;
    assign sc.scan_tick = tick_r;

    a_scan_seal_sample: assert property (@(posedge core_clk) disable iff (sys_rst)
        tick_r |=> (seal_r == $past(sc.sealed)))
        else $error("seal-in status not sampled on scan tick");
endmodule

/* hdl/iosf_top.sv */
// How it works
// - byte two: inputs nine-eleven, seal status zero, coil continuity, power status.
// - armed seal-in circuit latches the true output state to keep it energized.
// - seal-in status is sampled into the input image every scan cycle.
// - on link timeout, latest seal status is evaluated before any output changes.
// - after timeout, a sealed output channel stays energized.
// - after timeout, an unsealed output channel is cleared for failsafe.
// - a normal update message loads both output bits into the output latch.
//
// Design decisions made here: strobed register access and the register offsets.
module iosf_top
    import iosf_pkg::*;
#(
    parameter int SCAN_CYCLES    = SCAN_CYCLES_DEF,
    parameter int TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF
)
(
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              sys_rst,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [DATA_W-1:0] reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [DATA_W-1:0] reg_rdata,
    // controller serial link, decoded messages
    input  wire logic              msg_valid,
    input  wire logic              msg_update,
    input  wire logic [BYTE_W-1:0] msg_data,
    output logic      [BYTE_W-1:0] resp_byte0,
    output logic      [BYTE_W-1:0] resp_byte1,
    // board pins
    input  wire logic [NUM_DI-1:0] discrete_input,
    input  wire logic [NUM_DO-1:0] coil_ok_pin,
    input  wire logic [NUM_DO-1:0] power_ok_pin,
    input  wire logic [NUM_DO-1:0] seal_volt_pin,
    input  wire logic [NUM_DO-1:0] latch_enable_switch,
    output logic      [NUM_DO-1:0] do_out,
    // status
    output logic                   link_lost,
    output logic                   irq
);
    localparam int B0_LSB = 0;
    localparam int HI_DI  = NUM_DI - BYTE_W;

    iosf_scan_if sc ();

    iosf_scan #(
        .SCAN_CYCLES         (SCAN_CYCLES)
    ) u_scan (
        .core_clk            (core_clk),
        .sys_rst             (sys_rst),
        .discrete_input      (discrete_input),
        .coil_ok_pin         (coil_ok_pin),
        .power_ok_pin        (power_ok_pin),
        .seal_volt_pin       (seal_volt_pin),
        .latch_enable_switch (latch_enable_switch),
        .sc                  (sc)
    );

    // link and output state
    iosf_link_type     state_r, state_nxt;
    logic [CNT_W-1:0]  to_cnt_r, to_cnt_nxt;
    logic [NUM_DO-1:0] do_latch_r, do_latch_nxt;
    logic [NUM_DO-1:0] sealed_r, sealed_nxt;
    logic [NUM_DO-1:0] keep_r, keep_nxt;
    logic [NUM_DO-1:0] do_out_r, do_out_nxt;
    logic              lost_r, lost_nxt;
    logic              fs_en_r, fs_en_nxt;
    logic              timed_out;
    logic              upd_ok;
    logic [EV_W-1:0]   ev;

    always_comb
    begin
        state_nxt    = state_r;
        do_latch_nxt = do_latch_r;
        keep_nxt     = keep_r;
        ev           = '0;
        timed_out    = (to_cnt_r == CNT_W'(TIMEOUT_CYCLES - 1));
        upd_ok       = msg_valid && msg_update && (state_r == LINK_OK || state_r == LINK_LOST);
        to_cnt_nxt   = to_cnt_r;
        // counter stops at the limit, so a long silence never wraps into a fresh window
        if (msg_valid)
            to_cnt_nxt = '0;
        else if (!timed_out)
            to_cnt_nxt = to_cnt_r + 1'b1;
        unique case (state_r)
            LINK_OK:
            begin
                if (!msg_valid && timed_out)
                begin
                    state_nxt      = LINK_CHECK;
                    ev[EV_TIMEOUT] = 1'b1;
                end
            end
            LINK_CHECK:
            begin
                // outputs untouched here; only the latest scanned seal status is read
                keep_nxt  = sc.seal_stat;
                state_nxt = LINK_APPLY;
            end
            LINK_APPLY:
            begin
                if (fs_en_r)
                begin
                    do_latch_nxt    = do_latch_r & keep_r;
                    ev[EV_FAILSAFE] = 1'b1;
                end
                state_nxt = LINK_LOST;
            end
            LINK_LOST:
            begin
                if (msg_valid)
                    state_nxt = LINK_OK;
            end
        endcase
        // updates during the two-cycle evaluation are dropped to keep it atomic
        if (upd_ok)
        begin
            do_latch_nxt  = msg_data[CMD_DO_LSB +: NUM_DO];
            ev[EV_UPDATE] = 1'b1;
        end
        // seal-in holds the true state while armed; a timeout reads it back
        sealed_nxt = sc.seal_cfg & do_latch_r;
        do_out_nxt = do_latch_nxt;
        lost_nxt   = (state_nxt != LINK_OK);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            state_r    <= LINK_OK;
            to_cnt_r   <= '0;
            do_latch_r <= '0;
            sealed_r   <= '0;
            keep_r     <= '0;
            do_out_r   <= '0;
            lost_r     <= 1'b0;
        end
        else
        begin
            state_r    <= state_nxt;
            to_cnt_r   <= to_cnt_nxt;
            do_latch_r <= do_latch_nxt;
            sealed_r   <= sealed_nxt;
            keep_r     <= keep_nxt;
            do_out_r   <= do_out_nxt;
            lost_r     <= lost_nxt;
        end
    end

    // seal status feeds back to the scan, which picks it up only on its tick
    assign sc.sealed = sealed_r;

    // response image
    logic [BYTE_W-1:0] resp0_r, resp0_nxt, resp1_r, resp1_nxt;

    always_comb
    begin
        // rebuilt every cycle, but only moves when the scan refreshes its latches
        resp0_nxt = sc.di[B0_LSB +: BYTE_W];
        resp1_nxt = '0;
        resp1_nxt[B1_DI_LSB +: HI_DI]    = sc.di[BYTE_W +: HI_DI];
        resp1_nxt[B1_SEAL0]              = sc.seal_stat[0];
        resp1_nxt[B1_COIL_LSB +: NUM_DO] = sc.coil;
        resp1_nxt[B1_PWR_LSB +: NUM_DO]  = sc.pwr;
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            resp0_r <= '0;
            resp1_r <= '0;
        end
        else
        begin
            resp0_r <= resp0_nxt;
            resp1_r <= resp1_nxt;
        end
    end

    // registers and interrupt
    logic [EV_W-1:0]   status_r, status_nxt, mask_r, mask_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic              irq_r, irq_nxt;

    always_comb
    begin
        mask_nxt  = mask_r;
        fs_en_nxt = fs_en_r;
        rdata_nxt = '0;
        if (reg_wr && reg_addr == OFS_MASK)
            mask_nxt = reg_wdata[EV_W-1:0];
        if (reg_wr && reg_addr == OFS_CTRL)
            fs_en_nxt = reg_wdata[CTRL_FS_EN];
        // new events win over the read that clears
        status_nxt = ((reg_rd && reg_addr == OFS_STATUS) ? '0 : status_r) | ev;
        if (reg_rd)
        begin
            unique case (reg_addr)
                OFS_STATUS: rdata_nxt[EV_W-1:0] = status_r;
                OFS_MASK:   rdata_nxt[EV_W-1:0] = mask_r;
                OFS_IMAGE:  rdata_nxt = {resp1_r, resp0_r};
                OFS_OUTPUT:
                begin
                    rdata_nxt[OUT_DO_LSB +: NUM_DO]     = do_latch_r;
                    rdata_nxt[OUT_SEAL_LSB +: NUM_DO]   = sealed_r;
                    rdata_nxt[OUT_STATE_LSB +: STATE_W] = state_r;
                end
                OFS_CTRL:   rdata_nxt[CTRL_FS_EN] = fs_en_r;
                default:    rdata_nxt = '0;
            endcase
        end
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            status_r <= '0;
            mask_r   <= MASK_RST;
            fs_en_r  <= CTRL_FS_EN_RST;
            rdata_r  <= '0;
            irq_r    <= 1'b0;
        end
        else
        begin
            status_r <= status_nxt;
            mask_r   <= mask_nxt;
            fs_en_r  <= fs_en_nxt;
            rdata_r  <= rdata_nxt;
            irq_r    <= irq_nxt;
        end
    end

    assign reg_rdata  = rdata_r;
    assign resp_byte0 = resp0_r;
    assign resp_byte1 = resp1_r;
    assign do_out     = do_out_r;
    assign link_lost  = lost_r;
    assign irq        = irq_r;

    a_byte0_input_map: assert property (@(posedge core_clk) disable iff (sys_rst)
        ##1 (resp_byte0 == $past(sc.di[B0_LSB +: BYTE_W])))
        else $error("response byte one does not mirror inputs one to eight");

    a_byte1_status_map: assert property (@(posedge core_clk) disable iff (sys_rst)
        ##1 (resp_byte1[B1_SEAL0] == $past(sc.seal_stat[0])
             && resp_byte1[B1_PWR_LSB +: NUM_DO] == $past(sc.pwr)
             && resp_byte1[B1_COIL_LSB +: NUM_DO] == $past(sc.coil)
             && resp_byte1[B1_DI_LSB +: HI_DI] == $past(sc.di[BYTE_W +: HI_DI])))
        else $error("response byte two layout wrong");

    a_check_before_change: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == LINK_OK && !msg_valid && timed_out)
        |=> (state_r == LINK_CHECK) ##1 ((state_r == LINK_APPLY) && $stable(do_latch_r)))
        else $error("outputs changed before seal status was evaluated");

    // one copy per output channel
    for (genvar ch = 0; ch < NUM_DO; ch++)
    begin : g_chan
        a_seal_latch_true: assert property (@(posedge core_clk) disable iff (sys_rst)
            (sc.seal_cfg[ch] && do_latch_r[ch]) |=> sealed_r[ch])
            else $error("armed seal-in did not latch an energized output");

        a_keep_sealed: assert property (@(posedge core_clk) disable iff (sys_rst)
            (state_r == LINK_CHECK && sc.seal_stat[ch] && do_latch_r[ch]) |=> ##1 do_out[ch])
            else $error("sealed channel dropped after timeout");
    end

    a_clear_unsealed: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == LINK_CHECK && fs_en_r)
        |=> ##1 ((do_latch_r & ~$past(sc.seal_stat, 2)) == '0 && (do_out & ~$past(sc.seal_stat, 2)) == '0))
        else $error("unsealed channel not cleared after timeout");

    a_status_sticky: assert property (@(posedge core_clk) disable iff (sys_rst)
        (status_r[EV_TIMEOUT] && !(reg_rd && reg_addr == OFS_STATUS)) |=> status_r[EV_TIMEOUT])
        else $error("timeout status bit lost without a status read");

    a_rdata_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        !$past(reg_rd) |-> (reg_rdata == '0))
        else $error("read data present without a read");

    a_update_load: assert property (@(posedge core_clk) disable iff (sys_rst)
        (msg_valid && msg_update && (state_r == LINK_OK || state_r == LINK_LOST))
        |=> (do_out == $past(msg_data[CMD_DO_LSB +: NUM_DO])))
        else $error("update message not loaded into output latch");

    a_timeout_restart: assert property (@(posedge core_clk) disable iff (sys_rst)
        msg_valid |=> (to_cnt_r == '0) && !(state_r == LINK_CHECK))
        else $error("valid message did not restart the timeout counter");

    a_timeout_limit: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_r == LINK_OK && !msg_valid && to_cnt_r == CNT_W'(TIMEOUT_CYCLES - 1))
        |=> (state_r == LINK_CHECK) && link_lost)
        else $error("timeout not declared at the limit");
endmodule

/* verif/iosf_ctl_model.sv */
module iosf_ctl_model
    import iosf_pkg::*;
(
    // clock
    input  wire logic              core_clk,
    // decoded controller messages toward the board
    output logic                   msg_valid,
    output logic                   msg_update,
    output logic      [BYTE_W-1:0] msg_data
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [BYTE_W-1:0] last_data;

    initial
    begin
        msg_valid  = 1'b0;
        msg_update = 1'b0;
        msg_data   = 8'h00;
        last_data  = 8'h00;
    end

    // idle data shows the inverse, so a stale byte never passes for a command
    task automatic send_msg(input logic upd, input logic [BYTE_W-1:0] data);
        @(posedge core_clk);
        msg_valid  <= 1'b1;
        msg_update <= upd;
        msg_data   <= data;
        last_data  = data;
        @(posedge core_clk);
        msg_valid  <= 1'b0;
        msg_update <= 1'b0;
        msg_data   <= ~last_data;
    endtask

    // steady polling, each message restarts the board's link timer
    task automatic poll_every(input int gap, input int count);
        for (int i = 0; i < count; i++)
        begin
            send_msg(1'b0, 8'h00);
            repeat (gap) @(posedge core_clk);
        end
    endtask
endmodule

/* verif/iosf_top_test.sv */
module iosf_top_test;
    import iosf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int SCAN_T = 20;
    localparam int TOUT_T = 200;

    logic              core_clk;
    logic              sys_rst;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata;
    logic              reg_wr;
    logic              reg_rd;
    logic [DATA_W-1:0] reg_rdata;
    logic              msg_valid;
    logic              msg_update;
    logic [BYTE_W-1:0] msg_data;
    logic [BYTE_W-1:0] resp_byte0;
    logic [BYTE_W-1:0] resp_byte1;
    logic [NUM_DI-1:0] discrete_input;
    logic [NUM_DO-1:0] coil_ok_pin;
    logic [NUM_DO-1:0] power_ok_pin;
    logic [NUM_DO-1:0] seal_volt_pin;
    logic [NUM_DO-1:0] latch_enable_switch;
    logic [NUM_DO-1:0] do_out;
    logic              link_lost;
    logic              irq;
    int                num_errors;
    int                checks;

    iosf_top #(.SCAN_CYCLES(SCAN_T), .TIMEOUT_CYCLES(TOUT_T)) dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .msg_valid(msg_valid),
        .msg_update(msg_update), .msg_data(msg_data), .resp_byte0(resp_byte0), .resp_byte1(resp_byte1),
        .discrete_input(discrete_input), .coil_ok_pin(coil_ok_pin), .power_ok_pin(power_ok_pin),
        .seal_volt_pin(seal_volt_pin), .latch_enable_switch(latch_enable_switch), .do_out(do_out),
        .link_lost(link_lost), .irq(irq));

    iosf_ctl_model ctl (.core_clk(core_clk), .msg_valid(msg_valid), .msg_update(msg_update), .msg_data(msg_data));

    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    task automatic check(input string name, input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d checks %0d", num_errors, checks);
        if (num_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic t_reset_values();
        logic [DATA_W-1:0] d;
        reg_read(OFS_STATUS, d); check("status", d, 16'h0000);
        reg_read(OFS_CTRL, d);   check("ctrl", d, 16'h0001);
        reg_read(OFS_OUTPUT, d); check("output", d, 16'h0000);
        reg_read(8'h14, d);      check("unmapped", d, 16'h0000);
        reg_write(OFS_MASK, 16'h0005);
        reg_read(OFS_MASK, d);   check("mask rw", d, 16'h0005);
        reg_write(OFS_MASK, 16'h0000);
        reg_read(OFS_MASK, d);   check("mask zero", d, 16'h0000);
        reg_write(OFS_CTRL, 16'h0000);
        reg_read(OFS_CTRL, d);   check("ctrl off", d, 16'h0000);
        reg_write(OFS_CTRL, 16'h0001);
        reg_read(OFS_CTRL, d);   check("ctrl on", d, 16'h0001);
    endtask

    // both patterns flip every field but seal status zero, so a swapped or stuck bit shows
    task automatic t_image(input logic [10:0] di, input logic [1:0] cl, input logic [1:0] pw,
                           input logic [15:0] exp);
        logic [DATA_W-1:0] d;
        @(posedge core_clk);
        discrete_input <= di;
        coil_ok_pin    <= cl;
        power_ok_pin   <= pw;
        repeat (2 * SCAN_T + 8) @(posedge core_clk);
        #1;
        check("resp byte0", {8'h00, resp_byte0}, {8'h00, exp[7:0]});
        check("resp byte1", {8'h00, resp_byte1}, {8'h00, exp[15:8]});
        reg_read(OFS_IMAGE, d); check("image", d, exp);
    endtask

    task automatic t_update_seal();
        logic [DATA_W-1:0] d;
        logic [7:0]        cmd [3] = '{8'hFD, 8'hFE, 8'h03};
        reg_read(OFS_STATUS, d);
        foreach (cmd[i])
        begin
            ctl.send_msg(1'b1, cmd[i]);
            #1 check("do_out", {14'h0, do_out}, {14'h0, cmd[i][1:0]});
        end
        check("irq masked", {15'h0, irq}, 16'h0000);
        reg_write(OFS_MASK, 16'h0004);
        @(posedge core_clk);
        #1 check("irq unmasked", {15'h0, irq}, 16'h0001);
        reg_read(OFS_STATUS, d); check("status update", d, 16'h0004);
        @(posedge core_clk);
        #1 check("irq cleared", {15'h0, irq}, 16'h0000);
        @(posedge core_clk);
        seal_volt_pin       <= 2'b11;
        latch_enable_switch <= 2'b01;
        repeat (2 * SCAN_T + 8) @(posedge core_clk);
        #1 check("seal in image", {15'h0, resp_byte1[B1_SEAL0]}, 16'h0001);
        reg_read(OFS_OUTPUT, d); check("output sealed", d, 16'h0007);
    endtask

    task automatic t_timeout();
        logic [DATA_W-1:0] d;
        int                n;
        reg_write(OFS_MASK, 16'h0003);
        reg_read(OFS_STATUS, d);
        // the span is measured from the last message, which restarts the link timer
        ctl.send_msg(1'b0, 8'h00);
        n = 0;
        while (link_lost !== 1'b1 && n < TOUT_T + 50)
        begin
            @(posedge core_clk);
            #1 n++;
        end
        check("timeout span", 16'(n), 16'(TOUT_T));
        check("do before fs", {14'h0, do_out}, 16'h0003);
        repeat (2) @(posedge core_clk);
        #1 check("do after fs", {14'h0, do_out}, 16'h0001);
        check("irq fs", {15'h0, irq}, 16'h0001);
        reg_read(OFS_OUTPUT, d); check("output lost", d, 16'h0035);
        reg_read(OFS_STATUS, d); check("status fs", d, 16'h0003);
        ctl.send_msg(1'b0, 8'h00);
        @(posedge core_clk);
        #1 check("link back", {15'h0, link_lost}, 16'h0000);
    endtask

    task automatic t_restart();
        logic [DATA_W-1:0] d;
        reg_read(OFS_STATUS, d);
        ctl.poll_every(TOUT_T - 50, 4);
        #1 check("no loss", {15'h0, link_lost}, 16'h0000);
        reg_read(OFS_STATUS, d); check("no timeout", d, 16'h0000);
        check("kept", {14'h0, do_out}, 16'h0001);
    endtask

    initial
    begin
        num_errors          = 0;
        checks              = 0;
        sys_rst             = 1'b1;
        reg_addr            = 8'h00;
        reg_wdata           = 16'h0000;
        reg_wr              = 1'b0;
        reg_rd              = 1'b0;
        discrete_input      = 11'h000;
        coil_ok_pin         = 2'b00;
        power_ok_pin        = 2'b00;
        seal_volt_pin       = 2'b00;
        latch_enable_switch = 2'b00;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        t_reset_values();
        t_image(11'h5A3, 2'b10, 2'b01, 16'h65A3);
        t_image(11'h25C, 2'b01, 2'b10, 16'h925C);
        t_update_seal();
        t_timeout();
        t_restart();
        stop_test();
    end

    // generous bound, the whole sequence needs about 1000 cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end
endmodule
